// File: logic/pll_lock_defines.vh
/*
 * Constants of the loop supervisor: register addresses, field positions,
 * reset values and lock detector window and tolerance counts.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef PLL_LOCK_DEFINES_VH
`define PLL_LOCK_DEFINES_VH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define ADDR_CTRL      16'hFE0B
`define ADDR_BW        16'hFE0C
`define ADDR_PROG      16'hFE0D

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_IE        7
`define CTRL_FLAG      6
`define CTRL_ON        5
`define CTRL_BCS       4
`define BW_AUTO        7
`define BW_LOCK        6
`define BW_ACQ         5
`define PROG_N_HI      7
`define PROG_N_LO      4
`define PROG_L_HI      3
`define PROG_L_LO      0

// ----------------------------------------------------------------------
// reset values and fixed read bits
// ----------------------------------------------------------------------
`define CTRL_RST       4'h0
`define BW_RST         2'h0
`define PROG_RST       8'h00
`define CTRL_LOW_FILL  4'hF
`define BW_LOW_FILL    5'h00

// ----------------------------------------------------------------------
// lock detector window (reference edges) and tolerances (edge counts)
// ----------------------------------------------------------------------
`define WIN_REF_EDGES  8'h40
`define TOL_TRACK      8'h03
`define TOL_UNTRACK    8'h06
`define TOL_LOCK       8'h01
`define TOL_UNLOCK     8'h02

`endif

// File: logic/modulo_vco_divider.v
/*
 * Modulo divider of the sampled oscillator clock: one feedback edge pulse
 * per N oscillator edges, plus a feedback clock level at that rate.
 * Assumes vco_edge_i is a one-cycle pulse already on ref_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pll_lock_defines.vh"

module modulo_vco_divider (
   input  wire       ref_clk_i,
   input  wire       rstn_i,
   input  wire       enable_i,
   input  wire [3:0] n_i,
   input  wire       vco_edge_i,
   input  wire       vco_level_i,
   output reg        fb_edge_o,
   output reg        fb_clock_o
);

   reg  [3:0] count_q;
   wire [3:0] n_eff;
   wire       wrap;

   // zero divides like one
   assign n_eff = (n_i == 4'h0) ? 4'h1 : n_i;
   assign wrap  = (count_q >= n_eff - 4'h1);

   // count oscillator edges modulo n
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         count_q    <= 4'h0;
         fb_edge_o  <= 1'b0;
         fb_clock_o <= 1'b0;
      end else if (!enable_i) begin
         count_q    <= 4'h0;
         fb_edge_o  <= 1'b0;
         fb_clock_o <= 1'b0;
      end else begin
         fb_edge_o <= vco_edge_i & wrap;
         if (vco_edge_i) begin
            count_q <= wrap ? 4'h0 : count_q + 4'h1;
         end
         // first half of the period high; n of one follows the oscillator
         fb_clock_o <= (n_eff == 4'h1) ? vco_level_i : (count_q < {1'b0, n_eff[3:1]});
      end
   end

endmodule
`default_nettype wire

// File: logic/freq_window_meter.v
/*
 * Frequency comparator: counts feedback edges over a fixed window of
 * reference edges and reports the absolute difference at window end.
 * Assumes both edge inputs are one-cycle pulses on ref_clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pll_lock_defines.vh"

module freq_window_meter (
   input  wire       ref_clk_i,
   input  wire       rstn_i,
   input  wire       enable_i,
   input  wire       ref_edge_i,
   input  wire       fb_edge_i,
   output reg  [7:0] error_o,
   output reg        done_o
);

   reg  [7:0] ref_count_q;
   reg  [7:0] fb_count_q;
   wire [7:0] fb_total;

   // a feedback edge in the closing cycle still counts; saturate
   assign fb_total = (fb_edge_i && fb_count_q != 8'hFF) ? fb_count_q + 8'h01 : fb_count_q;

   // window counting, speed set by the reference rate
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ref_count_q <= 8'h00;
         fb_count_q  <= 8'h00;
         error_o     <= 8'hFF;
         done_o      <= 1'b0;
      end else if (!enable_i) begin
         ref_count_q <= 8'h00;
         fb_count_q  <= 8'h00;
         error_o     <= 8'hFF;
         done_o      <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (ref_edge_i && ref_count_q == `WIN_REF_EDGES - 8'h01) begin
            error_o     <= (fb_total > `WIN_REF_EDGES) ? fb_total - `WIN_REF_EDGES
                                                       : `WIN_REF_EDGES - fb_total;
            done_o      <= 1'b1;
            ref_count_q <= 8'h00;
            fb_count_q  <= 8'h00;
         end else begin
            fb_count_q <= fb_total;
            if (ref_edge_i) begin
               ref_count_q <= ref_count_q + 8'h01;
            end
         end
      end
   end

endmodule
`default_nettype wire

// File: logic/pll_bandwidth_lock_control.v
/*
 * Control and supervision logic of a clock-multiplying loop: feedback
 * divider, phase correction pulses, frequency lock detector, automatic or
 * manual bandwidth handling, control registers and lock-change interrupt.
 * Assumes a 100 MHz ref_clk_i well above the sampled oscillator and
 * reference clocks, and a register master that never waits.
 */
// Overview of operation
// - divide oscillator clock by programmed N
// - correction pulses from feedback versus reference phase
// - frequency compare gives mode and lock
// - acquisition flag zero means acquisition mode
// - automatic setting lets detector switch filter mode
// - automatic mode: acquisition flag read-only status
// - acquisition flag follows track/untrack tolerances
// - lock flag follows lock/unlock tolerances
// - lock toggle raises interrupt when enabled
// - manual mode: acquisition flag is writable control
// - manual mode: no lock flag, no interrupts
// - N in upper nibble, L lower
// - N of zero acts as one
// - L of zero disables loop, forces crystal
// - programming register read-only while loop on
`timescale 1ns/10ps
`default_nettype none
`include "pll_lock_defines.vh"

module pll_bandwidth_lock_control (
   input  wire        ref_clk_i,
   input  wire        rstn_i,
   // register port
   input  wire [15:0] addr_i,
   input  wire [7:0]  wr_data_i,
   input  wire        wr_en_i,
   input  wire        rd_en_i,
   output reg  [7:0]  rd_data_o,
   // clock pins sampled on ref_clk_i
   input  wire        vco_clock_i,
   input  wire        buffered_reference_clock_i,
   // loop outputs
   output reg         vco_feedback_clock_o,
   output reg         final_reference_clock_o,
   output reg         pump_up_o,
   output reg         pump_down_o,
   output wire        loop_enable_o,
   output wire        filter_acquisition_o,
   output wire        base_clock_select_o,
   output wire        lock_change_irq_o
);

   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   reg        irq_enable_q;
   reg        lock_change_flag_q;
   reg        loop_on_q;
   reg        base_select_q;
   reg        auto_q;
   reg        acq_q;
   reg        lock_q;
   reg  [7:0] prog_q;

   // ----------------------------------------------------------------------
   // pin sampling: three stages, change taken when stages two and three agree
   // ----------------------------------------------------------------------
   wire [1:0] pin_raw;
   reg  [1:0] pin_s1_q;
   reg  [1:0] pin_s2_q;
   reg  [1:0] pin_s3_q;
   reg  [1:0] pin_lvl_q;
   reg  [1:0] pin_rise_q;

   assign pin_raw = {buffered_reference_clock_i, vco_clock_i};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
         // sampling chain and filtered level per pin
         always @(posedge ref_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               pin_s1_q[gi]   <= 1'b0;
               pin_s2_q[gi]   <= 1'b0;
               pin_s3_q[gi]   <= 1'b0;
               pin_lvl_q[gi]  <= 1'b0;
               pin_rise_q[gi] <= 1'b0;
            end else begin
               pin_s1_q[gi] <= pin_raw[gi];
               pin_s2_q[gi] <= pin_s1_q[gi];
               pin_s3_q[gi] <= pin_s2_q[gi];
               if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                  pin_lvl_q[gi] <= pin_s3_q[gi];
               end
               pin_rise_q[gi] <= (pin_s2_q[gi] == pin_s3_q[gi]) & pin_s3_q[gi] & ~pin_lvl_q[gi];
            end
         end
      end
   endgenerate

   wire vco_edge = pin_rise_q[0];
   wire ref_edge = pin_rise_q[1];

   // ----------------------------------------------------------------------
   // loop enable and field split
   // ----------------------------------------------------------------------
   wire [3:0] n_field = prog_q[`PROG_N_HI:`PROG_N_LO];
   wire [3:0] l_field = prog_q[`PROG_L_HI:`PROG_L_LO];
   wire       l_zero  = (l_field == 4'h0);

   // loop runs only with a nonzero range multiplier
   assign loop_enable_o = loop_on_q & ~l_zero;

   // ----------------------------------------------------------------------
   // feedback divider
   // ----------------------------------------------------------------------
   wire fb_edge;
   wire fb_clock;

   modulo_vco_divider u_divider (
      .ref_clk_i   (ref_clk_i),
      .rstn_i      (rstn_i),
      .enable_i    (loop_enable_o),
      .n_i         (n_field),
      .vco_edge_i  (vco_edge),
      .vco_level_i (pin_lvl_q[0]),
      .fb_edge_o   (fb_edge),
      .fb_clock_o  (fb_clock)
   );

   // clock views out
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         vco_feedback_clock_o    <= 1'b0;
         final_reference_clock_o <= 1'b0;
      end else begin
         vco_feedback_clock_o    <= fb_clock;
         final_reference_clock_o <= pin_lvl_q[1];
      end
   end

   // ----------------------------------------------------------------------
   // phase detector: up from reference edge, down from feedback edge,
   // both dropped once both edges have arrived; width is the phase gap
   // ----------------------------------------------------------------------
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pump_up_o   <= 1'b0;
         pump_down_o <= 1'b0;
      end else if (!loop_enable_o) begin
         pump_up_o   <= 1'b0;
         pump_down_o <= 1'b0;
      end else begin
         if ((pump_up_o | ref_edge) & (pump_down_o | fb_edge)) begin
            pump_up_o   <= 1'b0;
            pump_down_o <= 1'b0;
         end else begin
            pump_up_o   <= pump_up_o | ref_edge;
            pump_down_o <= pump_down_o | fb_edge;
         end
      end
   end

   // ----------------------------------------------------------------------
   // lock detector
   // ----------------------------------------------------------------------
   wire [7:0] freq_error;
   wire       window_done;

   freq_window_meter u_meter (
      .ref_clk_i  (ref_clk_i),
      .rstn_i     (rstn_i),
      .enable_i   (loop_enable_o),
      .ref_edge_i (ref_edge),
      .fb_edge_i  (fb_edge),
      .error_o    (freq_error),
      .done_o     (window_done)
   );

   // hysteresis: enter inside the tight bound, leave outside the loose one
   wire track_in  = (freq_error <= `TOL_TRACK);
   wire track_out = (freq_error >  `TOL_UNTRACK);
   wire lock_in   = (freq_error <= `TOL_LOCK);
   wire lock_out  = (freq_error >  `TOL_UNLOCK);

   reg  lock_d;
   reg  acq_auto_d;

   // next lock and automatic mode values from one window result
   always @* begin
      lock_d     = lock_q;
      acq_auto_d = acq_q;
      if (!auto_q || !loop_enable_o) begin
         lock_d     = 1'b0;
         acq_auto_d = 1'b0;
      end else if (window_done) begin
         if (!lock_q && lock_in) begin
            lock_d = 1'b1;
         end else if (lock_q && lock_out) begin
            lock_d = 1'b0;
         end
         if (!acq_q && track_in) begin
            acq_auto_d = 1'b1;
         end else if (acq_q && track_out) begin
            acq_auto_d = 1'b0;
         end
      end
   end

   wire lock_toggle = auto_q & (lock_d != lock_q);

   // ----------------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------------
   wire wr_ctrl = wr_en_i & (addr_i == `ADDR_CTRL);
   wire wr_bw   = wr_en_i & (addr_i == `ADDR_BW);
   wire wr_prog = wr_en_i & (addr_i == `ADDR_PROG);
   wire rd_ctrl = rd_en_i & (addr_i == `ADDR_CTRL);

   wire new_on  = wr_data_i[`CTRL_ON];
   wire new_bcs = wr_data_i[`CTRL_BCS];

   // control register: loop on locked while selected; selection needs the
   // loop already on, nonzero L, and no loop switch in the same write
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {irq_enable_q, loop_on_q, base_select_q} <= 3'h0;
      end else begin
         if (wr_ctrl) begin
            irq_enable_q <= wr_data_i[`CTRL_IE] & auto_q;
            if (!base_select_q) begin
               loop_on_q <= new_on;
            end
            base_select_q <= new_bcs & loop_on_q & new_on & ~l_zero;
         end
         if (!auto_q) begin
            irq_enable_q <= 1'b0;
         end
         if (l_zero | ~loop_on_q) begin
            base_select_q <= 1'b0;
         end
      end
   end

   // lock-change flag: set on any lock toggle in automatic mode, cleared by a control read;
   // a set in the clearing cycle wins
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lock_change_flag_q <= 1'b0;
      end else if (!auto_q) begin
         lock_change_flag_q <= 1'b0;
      end else if (lock_toggle) begin
         lock_change_flag_q <= 1'b1;
      end else if (rd_ctrl) begin
         lock_change_flag_q <= 1'b0;
      end
   end

   // bandwidth register: acquisition flag is status in automatic mode
   // and a plain control in manual mode
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {auto_q, acq_q} <= `BW_RST;
         lock_q          <= 1'b0;
      end else begin
         lock_q <= lock_d;
         if (wr_bw) begin
            auto_q <= wr_data_i[`BW_AUTO];
         end
         if (auto_q) begin
            acq_q <= acq_auto_d;
         end else if (wr_bw) begin
            acq_q <= wr_data_i[`BW_ACQ];
         end
      end
   end

   // programming register frozen while the loop switch is on
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prog_q <= `PROG_RST;
      end else if (wr_prog && !loop_on_q) begin
         prog_q <= wr_data_i;
      end
   end

   // ----------------------------------------------------------------------
   // read data, standing in the cycle after the strobe only
   // ----------------------------------------------------------------------
   reg [7:0] rd_mux;

   always @* begin
      case (addr_i)
         `ADDR_CTRL: rd_mux = {irq_enable_q, lock_change_flag_q, loop_on_q, base_select_q,
                               `CTRL_LOW_FILL};
         `ADDR_BW:   rd_mux = {auto_q, lock_q & auto_q, acq_q, `BW_LOW_FILL};
         `ADDR_PROG: rd_mux = prog_q;
         default:    rd_mux = 8'h00;
      endcase
   end

   // registered read port
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= rd_en_i ? rd_mux : 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // filter mode, base clock choice and interrupt
   // ----------------------------------------------------------------------
   // acquisition when the flag is zero and the loop is enabled; tracking otherwise
   assign filter_acquisition_o = loop_enable_o & ~acq_q;
   assign base_clock_select_o  = base_select_q & ~l_zero;
   assign lock_change_irq_o    = lock_change_flag_q & irq_enable_q & auto_q;

endmodule
`default_nettype wire

// File: tb/pll_bandwidth_lock_control_monitor.sv
/*
 * Checker of the loop supervisor: register read slot, fixed read bits and
 * dependencies between loop enable, filter mode and base clock select.
 * Assumes it is bound into the top design module and sees its ports only.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pll_lock_defines.vh"

module pll_bandwidth_lock_control_monitor (
   input wire logic        ref_clk_i,
   input wire logic        rstn_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0]  wr_data_i,
   input wire logic        wr_en_i,
   input wire logic        rd_en_i,
   input wire logic [7:0]  rd_data_o,
   input wire logic        loop_enable_o,
   input wire logic        filter_acquisition_o,
   input wire logic        base_clock_select_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   chk_idle_read_zero: assert property (
      !$past(rd_en_i) |-> rd_data_o == 8'h00)
      else $error("read data outside its slot");
   chk_ctrl_low_ones: assert property (
      $past(rd_en_i) && $past(addr_i) == `ADDR_CTRL |-> rd_data_o[3:0] == 4'hF)
      else $error("control low bits not ones");
   chk_bw_low_zero: assert property (
      $past(rd_en_i) && $past(addr_i) == `ADDR_BW |-> rd_data_o[4:0] == 5'h00)
      else $error("bandwidth low bits not zero");
   chk_manual_lock_low: assert property (
      $past(rd_en_i) && $past(addr_i) == `ADDR_BW && !rd_data_o[7] |-> !rd_data_o[6])
      else $error("lock bit set in manual mode");

   // ----------------------------------------------------------------
   // loop outputs
   // ----------------------------------------------------------------
   chk_select_needs_loop: assert property (
      base_clock_select_o |-> loop_enable_o)
      else $error("select without enabled loop");
   chk_filter_needs_loop: assert property (
      filter_acquisition_o |-> loop_enable_o)
      else $error("acquisition filter with loop off");
   chk_loop_by_write: assert property (
      $changed(loop_enable_o) |-> $past(wr_en_i))
      else $error("loop enable moved without a write");
   chk_select_by_write: assert property (
      $rose(base_clock_select_o) |-> $past(wr_en_i) && $past(addr_i) == `ADDR_CTRL
         && $past(wr_data_i[5:4]) == 2'h3)
      else $error("select rose without select write");
endmodule

bind pll_bandwidth_lock_control pll_bandwidth_lock_control_monitor mon_u (
   .ref_clk_i            (ref_clk_i),
   .rstn_i               (rstn_i),
   .addr_i               (addr_i),
   .wr_data_i            (wr_data_i),
   .wr_en_i              (wr_en_i),
   .rd_en_i              (rd_en_i),
   .rd_data_o            (rd_data_o),
   .loop_enable_o        (loop_enable_o),
   .filter_acquisition_o (filter_acquisition_o),
   .base_clock_select_o  (base_clock_select_o)
);
`default_nettype wire

// File: tb/test_pll_bandwidth_lock_control.sv
/*
 * Self-checking bench of the loop supervisor: register table, automatic
 * lock and unlock, lock-change interrupt, divider rate, pump direction.
 * Assumes the design and its defines header are compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pll_lock_defines.vh"

module test_pll_bandwidth_lock_control;
   logic        ref_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0]  wr_data_i = 8'h00;
   logic        wr_en_i = 1'b0;
   logic        rd_en_i = 1'b0;
   logic        vco_clock_i = 1'b0;
   logic        buffered_reference_clock_i = 1'b0;
   logic        ref_run = 1'b0;
   logic        vco_run = 1'b0;
   logic        fb_q = 1'b0;
   logic        rdv_q = 1'b0;
   int          rdv_cnt = 0;
   logic [3:0]  ph = 4'h0;
   int          fb_cnt = 0;
   int          up_cnt = 0;
   int          dn_cnt = 0;
   int          cyc = 0;
   int          n_mismatch = 0;
   int          comparisons = 0;
   wire  [7:0]  rd_data_o;
   wire         fb_o, rdv_o, up_o, dn_o, en_o, fa_o, bcs_o, irq_o;
   // rows: address, write data, read back, {en, filter acq, select}
   logic [35:0] rows [17] = '{
      {16'hFE0D, 8'h23, 8'h23, 4'h0}, {16'hFE0C, 8'h20, 8'h20, 4'h0},
      {16'hFE0C, 8'h00, 8'h00, 4'h0}, {16'hFE0B, 8'h80, 8'h0F, 4'h0},
      {16'hFE0B, 8'h20, 8'h2F, 4'h6}, {16'hFE0D, 8'h45, 8'h23, 4'h6},
      {16'hFE0C, 8'h20, 8'h20, 4'h4}, {16'hFE0B, 8'h30, 8'h3F, 4'h5},
      {16'hFE0B, 8'h00, 8'h2F, 4'h4}, {16'hFE0B, 8'h20, 8'h2F, 4'h4},
      {16'hFE0B, 8'h00, 8'h0F, 4'h0}, {16'hFE0C, 8'h00, 8'h00, 4'h0},
      {16'hFE0D, 8'h20, 8'h20, 4'h0}, {16'hFE0B, 8'h20, 8'h2F, 4'h0},
      {16'hFE0B, 8'h30, 8'h2F, 4'h0}, {16'hFE0B, 8'h00, 8'h0F, 4'h0},
      {16'hFE0E, 8'hFF, 8'h00, 4'h0}};

   pll_bandwidth_lock_control dut_u (
      .ref_clk_i                  (ref_clk_i),
      .rstn_i                     (rstn_i),
      .addr_i                     (addr_i),
      .wr_data_i                  (wr_data_i),
      .wr_en_i                    (wr_en_i),
      .rd_en_i                    (rd_en_i),
      .rd_data_o                  (rd_data_o),
      .vco_clock_i                (vco_clock_i),
      .buffered_reference_clock_i (buffered_reference_clock_i),
      .vco_feedback_clock_o       (fb_o),
      .final_reference_clock_o    (rdv_o),
      .pump_up_o                  (up_o),
      .pump_down_o                (dn_o),
      .loop_enable_o              (en_o),
      .filter_acquisition_o       (fa_o),
      .base_clock_select_o        (bcs_o),
      .lock_change_irq_o          (irq_o)
   );

   // ----------------------------------------------------------------
   // clock, pin clocks (ref 20 cycles, oscillator 10), counters
   // ----------------------------------------------------------------
   always #5 ref_clk_i = ~ref_clk_i;

   always @(posedge ref_clk_i) begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      if (ref_run && ph == 4'h9) buffered_reference_clock_i <= ~buffered_reference_clock_i;
      if (vco_run && (ph == 4'h4 || ph == 4'h9)) vco_clock_i <= ~vco_clock_i;
      fb_q <= fb_o;
      if (fb_o && !fb_q) fb_cnt <= fb_cnt + 1;
      rdv_q <= rdv_o;
      if (rdv_o && !rdv_q) rdv_cnt <= rdv_cnt + 1;
      if (up_o) up_cnt <= up_cnt + 1;
      if (dn_o) dn_cnt <= dn_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_en_i <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_en_i <= 1'b0;
      #1;
      d = rd_data_o;
   endtask

   // poll the lock bit until it reads the wanted level
   task automatic wait_lock(input logic want);
      logic [7:0] d;
      for (int i = 0; i < 80; i++) begin
         repeat (100) @(posedge ref_clk_i);
         rd(`ADDR_BW, d);
         if (d[6] === want) break;
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] d;
      int m;
      int r;
      repeat (5) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      chk("outs", {fb_o, rdv_o, up_o, dn_o, en_o, fa_o, bcs_o, irq_o}, 8'h00);
      rd(`ADDR_CTRL, d);
      chk("ctrl", d, 8'h0F);
      rd(`ADDR_PROG, d);
      chk("prog", d, 8'h00);
      for (int i = 0; i < 17; i++) begin
         wr(rows[i][35:20], rows[i][19:12]);
         rd(rows[i][35:20], d);
         chk("reg", d, rows[i][11:4]);
         chk("outs", {5'h00, en_o, fa_o, bcs_o}, {5'h00, rows[i][2:0]});
         chk("irq", irq_o, 1'b0);
      end
      // automatic mode: N 2, L 1, oscillator at twice the reference
      wr(`ADDR_PROG, 8'h21);
      wr(`ADDR_BW, 8'h80);
      wr(`ADDR_CTRL, 8'hA0);
      rd(`ADDR_CTRL, d);
      chk("ctrl", d, 8'hAF);
      ref_run <= 1'b1;
      vco_run <= 1'b1;
      wait_lock(1'b1);
      chk("irq", irq_o, 1'b1);
      chk("facq", fa_o, 1'b0);
      rd(`ADDR_BW, d);
      chk("bw", d, 8'hE0);
      m = fb_cnt;
      r = rdv_cnt;
      repeat (400) @(posedge ref_clk_i);
      #1;
      chk("fb", 8'(fb_cnt - m), 8'h14);
      chk("rdv", 8'(rdv_cnt - r), 8'h14);
      wr(`ADDR_CTRL, 8'hB0);
      rd(`ADDR_CTRL, d);
      chk("ctrl", d, 8'hFF);
      repeat (2) @(posedge ref_clk_i);
      chk("irq", irq_o, 1'b0);
      wr(`ADDR_BW, 8'h80);
      rd(`ADDR_BW, d);
      chk("bw", d, 8'hE0);
      // oscillator stops: lock and tracking both lost
      vco_run <= 1'b0;
      m = up_cnt;
      wait_lock(1'b0);
      rd(`ADDR_BW, d);
      chk("bw", d, 8'h80);
      chk("irq", irq_o, 1'b1);
      chk("facq", fa_o, 1'b1);
      chk("up", up_cnt > m, 1'b1);
      wr(`ADDR_CTRL, 8'hA0);
      #1;
      chk("bcs", bcs_o, 1'b0);
      ref_run <= 1'b0;
      vco_run <= 1'b1;
      m = dn_cnt;
      repeat (300) @(posedge ref_clk_i);
      chk("down", dn_cnt > m, 1'b1);
      // second reset in mid-run
      rstn_i <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      chk("outs", {fb_o, rdv_o, up_o, dn_o, en_o, fa_o, bcs_o, irq_o}, 8'h00);
      rd(`ADDR_CTRL, d);
      chk("ctrl", d, 8'h0F);
      close_out();
   end
endmodule
`default_nettype wire
